// ===== rtl/tmr_cfg.svh
// Offsets, field positions, reset values and codes of the 16-bit timer.
`ifndef TMR_CFG_SVH
`define TMR_CFG_SVH
`define IDX_FLAGS     8'h0c
`define IDX_CNT_LO    8'h0e
`define IDX_CNT_HI    8'h0f
`define IDX_CTRL      8'h10
`define IDX_ENABLES   8'h8c
`define CTRL_RESET    8'h00
`define CTRL_MASK     8'h3f
`define OVF_BIT       0
`define OSC_EN_BIT    3
`define SET_MODE_CODE 4'hb
`define RESP_OKAY     2'b00
`define RESP_DECERR   2'b11
`endif

// ===== rtl/tmr_pkg.sv
// Types shared by the 16-bit timer/counter.
package tmr_pkg;
  // Control register layout, bit 7 down to bit 0.
  typedef struct packed {
    logic [1:0] rsv;
    logic [1:0] prescale_select;
    logic       osc_enable_bit;
    logic       sync_disable_bit;
    logic       clock_source_select;
    logic       timer_on_bit;
  } counter_control_t;

  // One pending AXI4-Lite write.
  typedef struct packed {
    logic        aw_held;
    logic        w_held;
    logic [7:0]  idx;
    logic [31:0] data;
    logic [3:0]  strb;
  } wr_slot_t;
endpackage

// ===== rtl/tmr_counter.sv
// Sixteen-bit timer/counter with prescaler and AXI4-Lite registers.
//
// How it works
// - sync disabled counts external ticks directly.
// - count bytes are read one at a time, with no latch between them.
// - oscillator amplifier on only with bit 3.
// - oscillator keeps running during sleep.
// - compare mode 1011 match clears counter.
// - trigger clear never sets overflow flag.
// - trigger clear ignored in asynchronous mode.
// - count write beats simultaneous trigger clear.
// - compare pair acts as counter period.
// - count bytes have no reset.
// - control register zero after power reset.
// - count byte write clears the prescaler.
// - bytes at 0Eh, 0Fh; control 10h.
// - source is clock, oscillator or pin.
// - prescaler divides by 1, 2, 4, 8.
// - asynchronous mode counts and wakes in sleep.
// - synchronized mode halts count in sleep.
//
// Local design decision: register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
`include "tmr_cfg.svh"
module tmr_counter
  import tmr_pkg::*;
(
  input  wire logic        clk_i,           // 25 MHz clock
  input  wire logic        rst_n_i,         // power-on reset
  input  wire logic [11:0] s_axi_awaddr,    // write address
  input  wire logic        s_axi_awvalid,   // write address valid
  output logic             s_axi_awready,   // write address ready
  input  wire logic [31:0] s_axi_wdata,     // write data
  input  wire logic [3:0]  s_axi_wstrb,     // byte enables
  input  wire logic        s_axi_wvalid,    // write data valid
  output logic             s_axi_wready,    // write data ready
  output logic [1:0]       s_axi_bresp,     // write response
  output logic             s_axi_bvalid,    // write response valid
  input  wire logic        s_axi_bready,    // write response ready
  input  wire logic [11:0] s_axi_araddr,    // read address
  input  wire logic        s_axi_arvalid,   // read address valid
  output logic             s_axi_arready,   // read address ready
  output logic [31:0]      s_axi_rdata,     // read data
  output logic [1:0]       s_axi_rresp,     // read response
  output logic             s_axi_rvalid,    // read data valid
  input  wire logic        s_axi_rready,    // read data ready
  input  wire logic        sleep_i,         // processor asleep
  input  wire logic        osc_input_pin_i, // oscillator input
  input  wire logic        ext_clock_pin_i, // external clock pin
  input  wire logic [3:0]  cmp_one_mode_i,  // unit one mode code
  input  wire logic        cmp_one_match_i, // unit one match
  input  wire logic [3:0]  cmp_two_mode_i,  // unit two mode code
  input  wire logic        cmp_two_match_i, // unit two match
  output logic             osc_amp_en_o,    // oscillator amplifier on
  output logic             wake_o           // overflow wake request
);

  // ---------------------------------------------------------------
  // Reset release and pin sampling
  // ---------------------------------------------------------------
  counter_control_t ctrl;
  logic [1:0]       rst_q;
  logic [2:0]       osc_s, ext_s;
  logic             rst_n, osc_f, ext_f, sel_prev, next_osc_f, next_ext_f, sel_level;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_q <= 2'b00;
    end else begin
      rst_q <= {rst_q[0], 1'b1};
    end
  end
  assign rst_n = rst_q[1];

  // A level counts only once the two later stages agree.
  always_comb begin
    next_osc_f = (osc_s[1] == osc_s[2]) ? osc_s[2] : osc_f;
    next_ext_f = (ext_s[1] == ext_s[2]) ? ext_s[2] : ext_f;
    sel_level  = ctrl.osc_enable_bit ? osc_f : ext_f;
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      osc_s    <= 3'h0;
      ext_s    <= 3'h0;
      osc_f    <= 1'b0;
      ext_f    <= 1'b0;
      sel_prev <= 1'b0;
    end else begin
      osc_s    <= {osc_s[1:0], osc_input_pin_i};
      ext_s    <= {ext_s[1:0], ext_clock_pin_i};
      osc_f    <= next_osc_f;
      ext_f    <= next_ext_f;
      sel_prev <= sel_level;
    end
  end

  // ---------------------------------------------------------------
  // Prescaler and count
  // ---------------------------------------------------------------
  function automatic logic [2:0] div_mask(input logic [1:0] sel);
    case (sel)
      2'b00:   div_mask = 3'h0;
      2'b01:   div_mask = 3'h1;
      2'b10:   div_mask = 3'h3;
      default: div_mask = 3'h7;
    endcase
  endfunction

  function automatic logic set_trig(input logic [3:0] mode,
                                    input logic       match);
    set_trig = match && (mode == `SET_MODE_CODE);
  endfunction

  wr_slot_t    wr;
  logic [15:0] count, next_count;
  logic [2:0]  presc, next_presc;
  logic        sync_tick, next_sync_tick, ovf_flag, ovf_enable, set_clr, inc, set_ovf;
  logic        wr_do, wr_lo, wr_hi, wr_any, src_tick, presc_out, async_mode;

  always_comb begin
    wr_do  = wr.aw_held && wr.w_held && !s_axi_bvalid;
    wr_lo  = wr_do && wr.strb[0] && (wr.idx == `IDX_CNT_LO);
    wr_hi  = wr_do && wr.strb[0] && (wr.idx == `IDX_CNT_HI);
    wr_any = wr_lo || wr_hi;
    async_mode = ctrl.clock_source_select && ctrl.sync_disable_bit;
    // The instruction clock stops in sleep, so timer mode halts there.
    src_tick = ctrl.clock_source_select ? (sel_level && !sel_prev)
                                        : !sleep_i;
    presc_out = src_tick &&
                ((presc & div_mask(ctrl.prescale_select)) ==
                 div_mask(ctrl.prescale_select));
    // On an external source the prescaler keeps dividing in sleep; synchronized mode only gates the increment.
    next_presc = presc;
    if (wr_any) next_presc = 3'h0;
    else if (src_tick) next_presc = presc + 3'h1;
    next_sync_tick = presc_out && !async_mode;
    inc = ctrl.timer_on_bit &&
          (async_mode ? presc_out
                      : (sync_tick && !sleep_i));
    // Clearing on a match makes the compare pair the period.
    set_clr = (set_trig(cmp_one_mode_i, cmp_one_match_i) ||
               set_trig(cmp_two_mode_i, cmp_two_match_i)) &&
              !async_mode;
    set_ovf = inc && !wr_any && !set_clr &&
              (count == 16'hffff);
    next_count = count;
    if (wr_any) begin
      if (wr_lo) next_count[7:0] = wr.data[7:0];
      if (wr_hi) next_count[15:8] = wr.data[7:0];
    end else if (set_clr) begin
      next_count = 16'h0000;
    end else if (inc) begin
      next_count = count + 16'h0001;
    end
  end

  // The count has no reset; only count byte writes, trigger clears and increments change it.
  always_ff @(posedge clk_i) begin
    count <= next_count;
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      presc     <= 3'h0;
      sync_tick <= 1'b0;
    end else begin
      presc     <= next_presc;
      sync_tick <= next_sync_tick;
    end
  end

  // ---------------------------------------------------------------
  // Register file
  // ---------------------------------------------------------------
  counter_control_t next_ctrl;
  logic             next_ovf_flag, next_ovf_enable, next_wake;

  always_comb begin
    next_ctrl       = ctrl;
    next_ovf_enable = ovf_enable;
    next_ovf_flag   = ovf_flag;
    if (wr_do && wr.strb[0]) begin
      if (wr.idx == `IDX_CTRL) next_ctrl = counter_control_t'(wr.data[7:0] & `CTRL_MASK);
      if (wr.idx == `IDX_ENABLES) next_ovf_enable = wr.data[`OVF_BIT];
      if (wr.idx == `IDX_FLAGS) next_ovf_flag = wr.data[`OVF_BIT];
    end
    if (set_ovf) next_ovf_flag = 1'b1;
    next_wake = next_ovf_flag && next_ovf_enable;
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      ctrl       <= counter_control_t'(`CTRL_RESET);
      ovf_flag   <= 1'b0;
      ovf_enable <= 1'b0;
      wake_o     <= 1'b0;
    end else begin
      ctrl       <= next_ctrl;
      ovf_flag   <= next_ovf_flag;
      ovf_enable <= next_ovf_enable;
      wake_o     <= next_wake;
    end
  end

  // Amplifier follows only the enable bit, not sleep.
  assign osc_amp_en_o = ctrl.osc_enable_bit;
  function automatic logic [31:0] rd_mux(input logic [7:0] idx);
    case (idx)
      `IDX_FLAGS:   rd_mux = {31'h0, ovf_flag};
      `IDX_ENABLES: rd_mux = {31'h0, ovf_enable};
      `IDX_CNT_LO:  rd_mux = {24'h0, count[7:0]};
      `IDX_CNT_HI:  rd_mux = {24'h0, count[15:8]};
      `IDX_CTRL:    rd_mux = {24'h0, ctrl};
      default:      rd_mux = 32'h0;
    endcase
  endfunction

  function automatic logic mapped(input logic [7:0] idx);
    mapped = (idx == `IDX_FLAGS) || (idx == `IDX_ENABLES) ||
             (idx == `IDX_CNT_LO) || (idx == `IDX_CNT_HI) ||
             (idx == `IDX_CTRL);
  endfunction

  // ---------------------------------------------------------------
  // AXI4-Lite slave
  // ---------------------------------------------------------------
  wr_slot_t    next_wr;
  logic        next_bvalid, next_rvalid;
  logic [1:0]  next_bresp, next_rresp;
  logic [31:0] next_rdata;

  always_comb begin
    next_wr     = wr;
    next_bvalid = s_axi_bvalid && !s_axi_bready;
    next_bresp  = s_axi_bresp;
    if (s_axi_awvalid && s_axi_awready) begin
      next_wr.aw_held = 1'b1;
      next_wr.idx     = s_axi_awaddr[9:2];
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_wr.w_held = 1'b1;
      next_wr.data   = s_axi_wdata;
      next_wr.strb   = s_axi_wstrb;
    end
    if (wr_do) begin
      next_wr.aw_held = 1'b0;
      next_wr.w_held  = 1'b0;
      next_bvalid     = 1'b1;
      next_bresp      = mapped(wr.idx) ? `RESP_OKAY : `RESP_DECERR;
    end
    next_rvalid = s_axi_rvalid && !s_axi_rready;
    next_rdata  = s_axi_rdata;
    next_rresp  = s_axi_rresp;
    if (s_axi_arvalid && s_axi_arready) begin
      next_rvalid = 1'b1;
      next_rdata  = rd_mux(s_axi_araddr[9:2]);
      next_rresp  = mapped(s_axi_araddr[9:2]) ? `RESP_OKAY
                                              : `RESP_DECERR;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      wr            <= '0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'b00;
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0;
      s_axi_rresp   <= 2'b00;
    end else begin
      wr            <= next_wr;
      s_axi_awready <= !next_wr.aw_held && !next_bvalid;
      s_axi_wready  <= !next_wr.w_held && !next_bvalid;
      s_axi_bvalid  <= next_bvalid;
      s_axi_bresp   <= next_bresp;
      s_axi_arready <= !next_rvalid;
      s_axi_rvalid  <= next_rvalid;
      s_axi_rdata   <= next_rdata;
      s_axi_rresp   <= next_rresp;
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  // The count powers up unknown, so checks wait until both bytes are set.
  logic [1:0] known;
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      known <= 2'b00;
    end else begin
      known <= set_clr ? 2'b11 : (known | {wr_hi, wr_lo});
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n);
  write_wins_a: assert property (wr_lo |=> count[7:0] == $past(wr.data[7:0]))
    else $error("count write lost");
  trig_clear_a: assert property (set_clr && !wr_any |=>
    count == 16'h0000)
    else $error("trigger did not clear count");
  ovf_cause_a: assert property ($rose(ovf_flag) |->
    $past(inc) && !$past(set_clr) && $past(count) == 16'hffff ||
    $past(wr_do) && $past(wr.strb[0]) && $past(wr.idx) == `IDX_FLAGS && $past(wr.data[0]))
    else $error("overflow flag without rollover");
  presc_clear_a: assert property (wr_any |=> presc == 3'h0)
    else $error("prescaler not cleared by write");
  hold_off_a: assert property (&known && !ctrl.timer_on_bit &&
    !wr_any && !set_clr |=> $stable(count))
    else $error("count moved while timer off");
  sleep_sync_a: assert property (&known && sleep_i &&
    !async_mode && !wr_any && !set_clr |=> $stable(count))
    else $error("synchronized count moved in sleep");
  async_inc_a: assert property (&known && async_mode &&
    ctrl.timer_on_bit && presc_out && !wr_any |=>
    count == $past(count) + 16'h0001)
    else $error("asynchronous tick not counted");
  osc_en_a: assert property (wr_do && wr.strb[0] &&
    wr.idx == `IDX_CTRL |=> osc_amp_en_o == $past(wr.data[3]))
    else $error("oscillator enable not applied");
  ctrl_rsv_a: assert property (ctrl.rsv == 2'b00)
    else $error("reserved control bits set");
  ovf_seen_c: cover property (set_ovf);
  clear_seen_c: cover property (set_clr && inc);
  clash_seen_c: cover property (set_clr && wr_any);
  sleep_count_c: cover property (sleep_i && async_mode && inc);
endmodule
`default_nettype wire

// ===== verification/ext_clock_src.sv
// Model of the crystal and the external clock source that feed the timer's pins.
`timescale 1ns/1ps
`default_nettype none
module ext_clock_src #(
  parameter int HALF  = 5,  // Half period, in clk_i cycles.
  parameter int START = 40  // Crystal start-up time, in clk_i cycles.
) (
  input  wire logic clk_i,     // bench clock
  input  wire logic amp_en_i,  // oscillator amplifier on
  input  wire logic run_i,     // external clock running
  output logic      osc_pin_o, // crystal swing on the oscillator input
  output logic      ext_pin_o  // external clock pin
);
  int ph = 0;
  int up = 0;
  // The crystal swings only after the amplifier has been on for its start-up time.
  // Sleep is not an input: the crystal keeps running whatever the processor does.
  always @(posedge clk_i) begin
    ph <= (ph == 2 * HALF - 1) ? 0 : ph + 1;
    up <= amp_en_i ? ((up < START) ? up + 1 : up) : 0;
    osc_pin_o <= (up == START) && (ph < HALF);
    ext_pin_o <= run_i && (ph < HALF);
  end
endmodule
`default_nettype wire

// ===== verification/test_tmr_counter.sv
// Self-checking testbench of the 16-bit timer/counter.
`timescale 1ns/1ps
`default_nettype none
`include "tmr_cfg.svh"
module test_tmr_counter;
  import tmr_pkg::*;
  localparam logic [11:0] A_FLG = 12'h030, A_LO = 12'h038, A_HI = 12'h03c;
  localparam logic [11:0] A_CTL = 12'h040, A_ENA = 12'h230, A_GLB = 12'h02c;
  localparam int HALF = 5;
  localparam int E = 200 / (2 * HALF);
  logic        clk_i = 1'b0, rst_n_i = 1'b0, sleep_i = 1'b0, run = 1'b0;
  logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, v;
  logic [3:0]  s_axi_wstrb = 4'hf, cmp_one_mode_i = 4'h0, cmp_two_mode_i = 4'h0, md;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, cmp_one_match_i = 1'b0;
  logic        cmp_two_match_i = 1'b0, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic        s_axi_arready, s_axi_rvalid, osc_input_pin_i, ext_clock_pin_i;
  logic        osc_amp_en_o, wake_o;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r;
  logic [15:0] cnt, c1;
  int          n_mismatch = 0, samples_checked = 0;

  always #20 clk_i = ~clk_i;

  tmr_counter i_tmr_counter (.clk_i, .rst_n_i, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .sleep_i, .osc_input_pin_i, .ext_clock_pin_i, .cmp_one_mode_i,
    .cmp_one_match_i, .cmp_two_mode_i, .cmp_two_match_i, .osc_amp_en_o, .wake_o);
  ext_clock_src #(.HALF(HALF)) i_ext_clock_src (.clk_i, .amp_en_i(osc_amp_en_o), .run_i(run),
    .osc_pin_o(osc_input_pin_i), .ext_pin_o(ext_clock_pin_i));

  // ----------------------------------------------------------------
  // Bus tasks and comparison
  // ----------------------------------------------------------------
  task automatic conclude;
    if (n_mismatch == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tick(input int k);
    repeat (k) @(posedge clk_i);
  endtask

  // A hung handshake counts as a mismatch and ends the run at once.
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    int n;
    n = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk_i);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (n > 50) begin
        n_mismatch++;
        conclude();
      end
    end while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic rd(input logic [11:0] a);
    int n;
    n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk_i);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (n > 50) begin
        n_mismatch++;
        conclude();
      end
    end while (!s_axi_rvalid);
    v = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge clk_i);
  endtask

  // High, low, high again; both bytes once more if the two highs differ.
  task automatic rd16;
    rd(A_HI);
    cnt[15:8] = v[7:0];
    rd(A_LO);
    cnt[7:0] = v[7:0];
    rd(A_HI);
    if (v[7:0] !== cnt[15:8]) begin
      rd(A_HI);
      cnt[15:8] = v[7:0];
      rd(A_LO);
      cnt[7:0] = v[7:0];
    end
  endtask

  task automatic load(input logic [15:0] c);
    wr(A_CTL, 8'h00);
    wr(A_LO, c[7:0]);
    wr(A_HI, c[15:8]);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    tick(5);
    rst_n_i <= 1'b1;
    tick(4);
    rd(A_CTL);
    chk(v, 32'h0);
    chk({30'h0, r}, {30'h0, `RESP_OKAY});
    rd(A_ENA);
    chk(v, 32'h0);
    rd(A_GLB);
    chk({30'h0, r}, {30'h0, `RESP_DECERR});
    wr(A_GLB, 8'h01);
    chk({30'h0, r}, {30'h0, `RESP_DECERR});
    wr(A_CTL, 8'hfe);
    chk({30'h0, r}, {30'h0, `RESP_OKAY});
    rd(A_CTL);
    chk(v, 32'h3e);
    chk({31'h0, osc_amp_en_o}, 32'h1);
    wr(A_ENA, 8'h01);
    load(16'hfff0);
    rd16;
    chk({16'h0, cnt}, 32'hfff0);
    chk({31'h0, osc_amp_en_o}, 32'h0);
    tick(20);
    rd16;
    chk({16'h0, cnt}, 32'hfff0);
    wr(A_CTL, 8'h01);
    tick(30);
    wr(A_CTL, 8'h00);
    rd(A_FLG);
    chk(v, 32'h1);
    chk({31'h0, wake_o}, 32'h1);
    rd16;
    chk({24'h0, cnt[15:8]}, 32'h0);
    wr(A_FLG, 8'h00);
    rd(A_FLG);
    chk(v, 32'h0);
    chk({31'h0, wake_o}, 32'h0);
    for (int k = 0; k < 4; k++) begin
      load(16'h0000);
      wr(A_CTL, {2'b00, k[1:0], 4'h1});
      tick(160);
      wr(A_CTL, 8'h00);
      rd16;
      if (k == 0) c1 = cnt;
      chk(32'(cnt + 1 >= (c1 >> k) && cnt <= (c1 >> k) + 1), 32'h1);
    end
    for (int k = 0; k < 4; k++) begin
      md = k[0] ? `SET_MODE_CODE : 4'ha;
      load(16'h1234);
      wr(A_CTL, 8'h01);
      cmp_one_mode_i <= md;
      cmp_two_mode_i <= md;
      cmp_one_match_i <= !k[1];
      cmp_two_match_i <= k[1];
      tick(1);
      cmp_one_match_i <= 1'b0;
      cmp_two_match_i <= 1'b0;
      tick(10);
      wr(A_CTL, 8'h00);
      rd16;
      chk({24'h0, cnt[15:8]}, k[0] ? 32'h0 : 32'h12);
      rd(A_FLG);
      chk(v, 32'h0);
    end
    load(16'h0000);
    run <= 1'b1;
    sleep_i <= 1'b1;
    wr(A_CTL, 8'h03);
    tick(200);
    rd16;
    chk({16'h0, cnt}, 32'h0);
    load(16'h0000);
    wr(A_CTL, 8'h07);
    tick(100);
    // A trigger in asynchronous mode must leave the count running.
    cmp_one_mode_i <= `SET_MODE_CODE;
    cmp_one_match_i <= 1'b1;
    tick(1);
    cmp_one_match_i <= 1'b0;
    tick(99);
    wr(A_CTL, 8'h00);
    rd16;
    chk(32'(cnt + 4 >= E && cnt <= E + 4), 32'h1);
    run <= 1'b0;
    // The crystal stays enabled through the load, so it need not restart.
    wr(A_CTL, 8'h08);
    tick(60);
    wr(A_LO, 8'h00);
    wr(A_HI, 8'h00);
    wr(A_CTL, 8'h0f);
    tick(200);
    wr(A_CTL, 8'h08);
    sleep_i <= 1'b0;
    rd16;
    chk(32'(cnt + 4 >= E && cnt <= E + 4), 32'h1);
    conclude();
  end
endmodule
`default_nettype wire
